// file: core/mcma_pkg.sv
// Shared constants and carrier types for the macrocell access block.
// Assumes every user of it names items as mcma_pkg::name.
package mcma_pkg;

    localparam int NUM_OMC = 16;
    localparam int NUM_IMC = 24;
    localparam int GRP_BITS = 8;
    localparam int NUM_NIBBLE = 6;

    // Offsets inside the configuration I/O space.
    localparam logic [7:0] OFS_CELL_GRP_ONE = 8'h20;
    localparam logic [7:0] OFS_CELL_GRP_TWO = 8'h21;
    localparam logic [7:0] OFS_MASK_AB = 8'h22;
    localparam logic [7:0] OFS_MASK_BC = 8'h23;
    localparam logic [7:0] OFS_INPUT_A = 8'h24;
    localparam logic [7:0] OFS_INPUT_B = 8'h25;
    localparam logic [7:0] OFS_INPUT_C = 8'h26;
    localparam logic [7:0] OFS_PORT_A_OUT = 8'h27;

    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] PORT_A_RESET = 8'h00;

    typedef enum logic [2:0] {
        MCMA_IMC_PASS = 3'b001,
        MCMA_IMC_LATCH = 3'b010,
        MCMA_IMC_REG = 3'b100
    } mcma_imc_mode_t;

    typedef struct packed {
        logic cs;
        logic [7:0] addr;
        logic wrN;
        logic rdN;
        logic ale;
        logic [7:0] data;
    } mcma_bus_t;

    typedef struct packed {
        logic [15:0] ptD;
        logic [15:0] ptClk;
        logic [15:0] ptPreset;
        logic [15:0] ptClear;
        logic [15:0] useLogicClk;
        logic [15:0] ptOe;
    } mcma_omc_term_t;

    typedef struct packed {
        logic [15:0] dirBit;
        logic [15:0] pinOutput;
        logic [15:0] hasEnable;
        logic [15:0] internalNode;
    } mcma_omc_cfg_t;

    typedef struct packed {
        logic slvCsN;
        logic slvRdN;
        logic slvWrN;
    } mcma_slave_t;

endpackage : mcma_pkg

// file: core/mcma_input_cells.sv
// The 24 input cells: latch, edge register or pass-through per cell.
// Assumes enables arrive synchronous to refClk, already selected.
`timescale 1ns/1ps
module mcma_input_cells (
    // Clock and reset
    input wire logic refClk,
    input wire logic srst,
    // Cell inputs
    input wire logic [23:0] portIn,
    input wire logic [23:0] cellEnable,
    input wire mcma_pkg::mcma_imc_mode_t cellMode [24],
    // Cell outputs
    output logic [23:0] cellOut
);

    typedef struct packed {
        logic [23:0] prevEn;
        logic [23:0] held;
    } mcma_imc_state_t;

    mcma_imc_state_t st;
    mcma_imc_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.prevEn = cellEnable;
        for (int i = 0; i < mcma_pkg::NUM_IMC; i++) begin
            case (cellMode[i])
                mcma_pkg::MCMA_IMC_PASS: begin
                    next_st.held[i] = portIn[i];
                end
                mcma_pkg::MCMA_IMC_LATCH: begin
                    if (cellEnable[i]) begin
                        next_st.held[i] = portIn[i];
                    end
                end
                mcma_pkg::MCMA_IMC_REG: begin
                    if (cellEnable[i] && !st.prevEn[i]) begin
                        next_st.held[i] = portIn[i];
                    end
                end
                default: begin
                    next_st.held[i] = portIn[i];
                end
            endcase
        end
    end

    always_ff @(posedge refClk) begin
        if (srst) begin
            st <= '0;
            // A register enable that is already high is no edge after reset.
            st.prevEn <= cellEnable;
        end else begin
            st <= next_st;
        end
    end

    assign cellOut = st.held;

endmodule : mcma_input_cells

// file: core/mcma_access.sv
// Processor access to the output and input macrocells of the logic array.
// Assumes all inputs are synchronous to refClk and the address decoder
// supplies the configuration-space select on the bus carrier.
`timescale 1ns/1ps
module mcma_access (
    // Clock and reset
    input wire logic refClk,
    input wire logic srst,
    // Processor bus
    input wire mcma_pkg::mcma_bus_t bus,
    output logic [7:0] busDataOut,
    output logic busDataOe,
    // Configuration choices
    input wire logic cfgLevelLoad,
    input wire logic cfgMailbox,
    input wire logic cfgCtlTwoUnused,
    input wire mcma_pkg::mcma_omc_cfg_t omcCfg,
    // Output cell terms from the logic array
    input wire mcma_pkg::mcma_omc_term_t omcTerm,
    input wire logic logicClockInput,
    // Output cell results
    output logic [15:0] cellFeedback,
    output logic [15:0] pinOut,
    output logic [15:0] pinOe,
    // Input cells
    input wire logic [23:0] portIn,
    input wire logic [23:0] cellSelAle,
    input wire logic [5:0] ptLatch,
    input wire mcma_pkg::mcma_imc_mode_t cellMode [24],
    output logic [23:0] inputCellOut,
    // Mailbox slave side
    input wire mcma_pkg::mcma_slave_t slave,
    output logic slaveRdTerm,
    output logic slaveWrTerm,
    output logic [7:0] portADrive,
    output logic portAOe,
    // Control pin two
    input wire logic controlPinTwo,
    output logic ctlTwoToArray
);

    typedef struct packed {
        logic [15:0] cellQ;
        logic [7:0] maskAb;
        logic [7:0] maskBc;
        logic [7:0] portAOut;
        logic wrPrev;
        logic wrCs;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
        logic [15:0] ptClkPrev;
        logic logicClkPrev;
        logic [7:0] rdData;
        logic rdOe;
        logic [15:0] pinOut;
        logic [15:0] pinOe;
        logic slaveRd;
        logic slaveWr;
        logic [7:0] portADrive;
        logic portAOe;
        logic ctlTwo;
    } mcma_top_state_t;

    mcma_top_state_t st;
    mcma_top_state_t next_st;

    logic [23:0] cellEnable;
    logic [23:0] imcQ;

    // Enable selection for the input cells.
    always_comb begin
        for (int i = 0; i < mcma_pkg::NUM_IMC; i++) begin
            if (cellSelAle[i]) begin
                cellEnable[i] = bus.ale;
            end else begin
                cellEnable[i] = ptLatch[i / 4];
                if (cfgMailbox && i < mcma_pkg::GRP_BITS) begin
                    cellEnable[i] = ptLatch[i / 4] | st.slaveWr;
                end
            end
        end
    end

    mcma_input_cells inputCells (
        .refClk(refClk),
        .srst(srst),
        .portIn(portIn),
        .cellEnable(cellEnable),
        .cellMode(cellMode),
        .cellOut(imcQ)
    );

    logic loadEvt;
    logic [7:0] loadAddr;
    logic [7:0] loadData;
    logic [15:0] loadBits;
    logic [15:0] loadMask;
    logic [15:0] ffClock;
    logic logicRise;

    always_comb begin
        next_st = st;
        // Capture the strobe cycle for edge loading.
        next_st.wrPrev = bus.wrN;
        if (!bus.wrN) begin
            next_st.wrCs = bus.cs;
            next_st.wrAddr = bus.addr;
            next_st.wrData = bus.data;
        end
        if (cfgLevelLoad) begin
            loadEvt = !bus.wrN && bus.cs;
            loadAddr = bus.addr;
            loadData = bus.data;
        end else begin
            loadEvt = bus.wrN && !st.wrPrev && st.wrCs;
            loadAddr = st.wrAddr;
            loadData = st.wrData;
        end

        // Mask and mailbox registers.
        if (loadEvt) begin
            case (loadAddr)
                mcma_pkg::OFS_MASK_AB: begin
                    next_st.maskAb = loadData;
                end
                mcma_pkg::OFS_MASK_BC: begin
                    next_st.maskBc = loadData;
                end
                mcma_pkg::OFS_PORT_A_OUT: begin
                    next_st.portAOut = loadData;
                end
                default: begin
                end
            endcase
        end

        // Which cells take a processor load this cycle.
        loadBits = '0;
        if (loadEvt && loadAddr == mcma_pkg::OFS_CELL_GRP_ONE) begin
            loadBits[7:0] = ~st.maskAb;
        end
        if (loadEvt && loadAddr == mcma_pkg::OFS_CELL_GRP_TWO) begin
            loadBits[15:8] = ~st.maskBc;
        end
        loadMask = loadBits;

        // Flip-flop clocking from a term or the logic clock input.
        logicRise = logicClockInput && !st.logicClkPrev;
        next_st.logicClkPrev = logicClockInput;
        next_st.ptClkPrev = omcTerm.ptClk;
        for (int i = 0; i < mcma_pkg::NUM_OMC; i++) begin
            if (omcTerm.useLogicClk[i]) begin
                ffClock[i] = logicRise;
            end else begin
                ffClock[i] = omcTerm.ptClk[i] && !st.ptClkPrev[i];
            end
            if (loadMask[i]) begin
                next_st.cellQ[i] = loadData[i % 8];
            end else if (omcTerm.ptPreset[i]) begin
                next_st.cellQ[i] = 1'b1;
            end else if (omcTerm.ptClear[i]) begin
                next_st.cellQ[i] = 1'b0;
            end else if (ffClock[i]) begin
                next_st.cellQ[i] = omcTerm.ptD[i];
            end
        end

        // Pin drive; an internal node leaves the pin to other use.
        next_st.pinOut = next_st.cellQ;
        for (int i = 0; i < mcma_pkg::NUM_OMC; i++) begin
            next_st.pinOe[i] = !omcCfg.internalNode[i] &&
                (omcTerm.ptOe[i] || omcCfg.dirBit[i] ||
                (omcCfg.pinOutput[i] && !omcCfg.hasEnable[i]));
        end

        // Read back of cells and registers.
        next_st.rdOe = 1'b0;
        next_st.rdData = '0;
        if (bus.cs && !bus.rdN) begin
            next_st.rdOe = 1'b1;
            case (bus.addr)
                mcma_pkg::OFS_CELL_GRP_ONE: begin
                    next_st.rdData = st.cellQ[7:0];
                end
                mcma_pkg::OFS_CELL_GRP_TWO: begin
                    next_st.rdData = st.cellQ[15:8];
                end
                mcma_pkg::OFS_MASK_AB: begin
                    next_st.rdData = st.maskAb;
                end
                mcma_pkg::OFS_MASK_BC: begin
                    next_st.rdData = st.maskBc;
                end
                mcma_pkg::OFS_INPUT_A: begin
                    next_st.rdData = imcQ[7:0];
                end
                mcma_pkg::OFS_INPUT_B: begin
                    next_st.rdData = imcQ[15:8];
                end
                mcma_pkg::OFS_INPUT_C: begin
                    next_st.rdData = imcQ[23:16];
                end
                mcma_pkg::OFS_PORT_A_OUT: begin
                    next_st.rdData = st.portAOut;
                end
                default: begin
                    next_st.rdOe = 1'b0;
                end
            endcase
        end

        // Mailbox slave terms and port A drive.
        next_st.slaveRd = cfgMailbox && !slave.slvCsN
            && !slave.slvRdN;
        next_st.slaveWr = cfgMailbox && !slave.slvCsN
            && !slave.slvWrN;
        next_st.portAOe = next_st.slaveRd;
        next_st.portADrive = next_st.portAOut;

        next_st.ctlTwo = cfgCtlTwoUnused && controlPinTwo;
    end

    always_ff @(posedge refClk) begin
        if (srst) begin
            st <= '0;
            st.maskAb <= mcma_pkg::MASK_RESET;
            st.maskBc <= mcma_pkg::MASK_RESET;
            st.portAOut <= mcma_pkg::PORT_A_RESET;
            st.wrPrev <= 1'b1;
            // The clock edge detectors start at their input's level, so a clock that
            // is already high when reset ends makes no false edge.
            st.logicClkPrev <= logicClockInput;
            st.ptClkPrev <= omcTerm.ptClk;
        end else begin
            st <= next_st;
        end
    end

    assign busDataOut = st.rdData;
    assign busDataOe = st.rdOe;
    assign cellFeedback = st.cellQ;
    assign pinOut = st.pinOut;
    assign pinOe = st.pinOe;
    assign inputCellOut = imcQ;
    assign slaveRdTerm = st.slaveRd;
    assign slaveWrTerm = st.slaveWr;
    assign portADrive = st.portADrive;
    assign portAOe = st.portAOe;
    assign ctlTwoToArray = st.ctlTwo;

endmodule : mcma_access

// file: sim/mcma_access_props.sv
// Concurrent checks on the macrocell access block ports.
// Assumes one clock domain, refClk, with srst as synchronous reset.
`timescale 1ns/1ps
module mcma_access_props (
    // Clock and reset
    input wire logic refClk,
    input wire logic srst,
    // Watched ports
    input wire mcma_pkg::mcma_bus_t bus,
    input wire logic busDataOe,
    input wire logic cfgMailbox,
    input wire logic cfgCtlTwoUnused,
    input wire mcma_pkg::mcma_omc_cfg_t omcCfg,
    input wire mcma_pkg::mcma_omc_term_t omcTerm,
    input wire logic [15:0] cellFeedback,
    input wire logic [15:0] pinOe,
    input wire logic [23:0] portIn,
    input wire mcma_pkg::mcma_imc_mode_t cellMode [24],
    input wire logic [23:0] inputCellOut,
    input wire mcma_pkg::mcma_slave_t slave,
    input wire logic slaveRdTerm,
    input wire logic slaveWrTerm,
    input wire logic portAOe,
    input wire logic controlPinTwo,
    input wire logic ctlTwoToArray
);
    default clocking @(posedge refClk);
    endclocking
    default disable iff (srst);

    a_preset_wins: assert property (bus.wrN && $past(bus.wrN) |=>
        (cellFeedback & $past(omcTerm.ptPreset)) == $past(omcTerm.ptPreset))
        else $error("preset did not set output cells");
    a_clear_acts: assert property (bus.wrN && $past(bus.wrN) |=>
        (cellFeedback & $past(omcTerm.ptClear & ~omcTerm.ptPreset)) == 0)
        else $error("clear did not reset output cells");
    a_pin_enable: assert property (1'b1 |=>
        pinOe == $past(~omcCfg.internalNode & (omcTerm.ptOe | omcCfg.dirBit
        | (omcCfg.pinOutput & ~omcCfg.hasEnable))))
        else $error("pin enable wrong");
    a_read_decode: assert property (bus.cs && !bus.rdN |=>
        busDataOe == ($past(bus.addr) >= mcma_pkg::OFS_CELL_GRP_ONE
        && $past(bus.addr) <= mcma_pkg::OFS_PORT_A_OUT))
        else $error("read drive enable wrong");
    a_slave_read: assert property (1'b1 |=> portAOe == slaveRdTerm &&
        slaveRdTerm == $past(cfgMailbox & !slave.slvCsN & !slave.slvRdN))
        else $error("slave read term wrong");
    a_slave_write: assert property (1'b1 |=>
        slaveWrTerm == $past(cfgMailbox & !slave.slvCsN & !slave.slvWrN))
        else $error("slave write term wrong");
    a_ctl_two: assert property (cfgCtlTwoUnused |=>
        ctlTwoToArray == $past(controlPinTwo))
        else $error("control pin two not passed");
    a_pass_cell: assert property (
        cellMode[0] == mcma_pkg::MCMA_IMC_PASS |=>
        inputCellOut[0] == $past(portIn[0]))
        else $error("pass cell did not follow pin");

    c_write: cover property (bus.cs && !bus.wrN);
    c_slave_read: cover property (slaveRdTerm);
    c_unmapped: cover property (bus.cs && !bus.rdN && bus.addr == 8'h30);
endmodule : mcma_access_props

bind mcma_access mcma_access_props mcma_access_props_inst (.refClk, .srst,
    .bus, .busDataOe, .cfgMailbox, .cfgCtlTwoUnused, .omcCfg, .omcTerm,
    .cellFeedback, .pinOe, .portIn, .cellMode, .inputCellOut, .slave,
    .slaveRdTerm, .slaveWrTerm, .portAOe, .controlPinTwo, .ctlTwoToArray);

// file: sim/mcma_mcu.sv
// Processor bus model: writes, reads and address strobes.
// Assumes the block samples every bus level on the rising refClk edge.
`timescale 1ns/1ps
module mcma_mcu (
    // Clock
    input wire logic refClk,
    // Bus toward the block
    output mcma_pkg::mcma_bus_t bus,
    input wire logic [7:0] busDataOut,
    input wire logic busDataOe
);
    localparam int DLY = 2;

    initial bus = '{1'b0, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00};

    // The strobe rises while select, address and data still stand.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge refClk);
        #DLY bus = '{1'b1, a, 1'b0, 1'b1, 1'b0, d};
        @(posedge refClk);
        #DLY bus.wrN = 1'b1;
        @(posedge refClk);
        #DLY bus = '{1'b0, ~a, 1'b1, 1'b1, 1'b0, ~d};
    endtask : write

    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic oe);
        @(posedge refClk);
        #DLY bus = '{1'b1, a, 1'b1, 1'b0, 1'b0, ~bus.data};
        @(posedge refClk);
        #1 d = busDataOut;
        oe = busDataOe;
        @(posedge refClk);
        #DLY bus = '{1'b0, ~a, 1'b1, 1'b1, 1'b0, ~bus.data};
    endtask : read

    task automatic strobe_addr();
        @(posedge refClk);
        #DLY bus.ale = 1'b1;
        @(posedge refClk);
        #DLY bus.ale = 1'b0;
    endtask : strobe_addr
endmodule : mcma_mcu

// file: sim/tb_top.sv
// Self-checking bench for the macrocell access block.
// Assumes the processor bus model drives all bus cycles.
`timescale 1ns/1ps
module tb_top;
    localparam int DLY = 2;
    logic refClk = 1'b0;
    logic srst = 1'b1;
    mcma_pkg::mcma_bus_t bus;
    logic [7:0] busDataOut, portADrive, rdData;
    logic busDataOe, slaveRdTerm, slaveWrTerm, portAOe, ctlTwoToArray, rdOe;
    logic cfgLevelLoad = 1'b0;
    logic cfgMailbox = 1'b0;
    logic cfgCtlTwoUnused = 1'b0;
    logic logicClockInput = 1'b0;
    logic controlPinTwo = 1'b0;
    mcma_pkg::mcma_omc_cfg_t omcCfg = '0;
    mcma_pkg::mcma_omc_term_t omcTerm = '0;
    logic [15:0] cellFeedback, pinOut, pinOe;
    logic [23:0] portIn = '0;
    logic [23:0] cellSelAle = '0;
    logic [23:0] inputCellOut;
    logic [5:0] ptLatch = '0;
    mcma_pkg::mcma_imc_mode_t cellMode [24];
    mcma_pkg::mcma_slave_t slave = 3'b111;
    logic [13:0] latchSeq [6] = '{14'h0311, 14'h0011, 14'h0077, 14'h0177,
                                  14'h0077, 14'h0000};
    int miscompares = 0;
    int samplesChecked = 0;

    mcma_mcu mcma_mcu_inst (.refClk, .bus, .busDataOut, .busDataOe);
    mcma_access mcma_access_inst (.refClk, .srst, .bus, .busDataOut,
        .busDataOe, .cfgLevelLoad, .cfgMailbox, .cfgCtlTwoUnused, .omcCfg,
        .omcTerm, .logicClockInput, .cellFeedback, .pinOut, .pinOe, .portIn,
        .cellSelAle, .ptLatch, .cellMode, .inputCellOut, .slave, .slaveRdTerm,
        .slaveWrTerm, .portADrive, .portAOe, .controlPinTwo, .ctlTwoToArray);

    initial forever #25 refClk = ~refClk;

    task automatic step(input int n);
        repeat (n) @(posedge refClk);
        #DLY;
    endtask : step

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        mcma_mcu_inst.read(a, rdData, rdOe);
        chk("readData", {8'h01, e}, {7'h0, rdOe, rdData});
    endtask : rdc

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge refClk);
        miscompares++;
        finish_test();
    end

    initial begin
        foreach (cellMode[i]) cellMode[i] = mcma_pkg::MCMA_IMC_PASS;
        step(10);
        srst = 1'b0;
        rdc(8'h22, 8'h00);
        rdc(8'h23, 8'h00);
        mcma_mcu_inst.write(8'h20, 8'h5a);
        rdc(8'h20, 8'h5a);
        mcma_mcu_inst.write(8'h22, 8'h0f);
        mcma_mcu_inst.write(8'h20, 8'hff);
        rdc(8'h20, 8'hfa);
        mcma_mcu_inst.write(8'h23, 8'hf0);
        mcma_mcu_inst.write(8'h21, 8'hc3);
        rdc(8'h21, 8'h03);
        cfgLevelLoad = 1'b1;
        mcma_mcu_inst.write(8'h22, 8'h00);
        omcTerm.ptPreset = 16'hffff;
        fork
            mcma_mcu_inst.write(8'h20, 8'h00);
            begin
                step(2);
                chk("cellFeedback", 16'hff00, cellFeedback);
            end
        join
        rdc(8'h20, 8'hff);
        omcTerm = '{ptClear: 16'hffff, default: 16'h0};
        step(2);
        omcTerm = '{ptD: 16'h1234, useLogicClk: 16'hffff, default: 16'h0};
        step(1);
        logicClockInput = 1'b1;
        step(3);
        rdc(8'h20, 8'h34);
        rdc(8'h21, 8'h12);
        chk("pinOut", 16'h1234, pinOut);
        omcCfg = '{16'h00ff, 16'h0f00, 16'h0300, 16'h0001};
        omcTerm.ptOe = 16'h1000;
        step(2);
        chk("pinOe", 16'h1cfe, pinOe);
        portIn = 24'ha5c33c;
        step(2);
        rdc(8'h24, 8'h3c);
        rdc(8'h25, 8'hc3);
        rdc(8'h26, 8'ha5);
        for (int i = 0; i < 8; i++) cellMode[i] = mcma_pkg::MCMA_IMC_LATCH;
        foreach (latchSeq[i]) begin
            {ptLatch, portIn[7:0]} = latchSeq[i];
            step(3);
        end
        rdc(8'h24, 8'h17);
        for (int i = 16; i < 24; i++) cellMode[i] = mcma_pkg::MCMA_IMC_REG;
        cellSelAle[23:16] = 8'hff;
        portIn[23:16] = 8'h9e;
        mcma_mcu_inst.strobe_addr();
        step(2);
        portIn[23:16] = 8'h61;
        step(2);
        rdc(8'h26, 8'h9e);
        cfgMailbox = 1'b1;
        mcma_mcu_inst.write(8'h27, 8'h6d);
        slave = '{1'b0, 1'b0, 1'b1};
        step(2);
        chk("portADrive", 16'h016d, {7'h0, portAOe, portADrive});
        slave = '{1'b0, 1'b1, 1'b0};
        portIn[7:0] = 8'h4b;
        step(3);
        slave = 3'b111;
        step(3);
        portIn[7:0] = 8'hb4;
        rdc(8'h24, 8'h4b);
        cfgCtlTwoUnused = 1'b1;
        controlPinTwo = 1'b1;
        step(2);
        chk("ctlTwoToArray", 16'h0001, {15'h0, ctlTwoToArray});
        mcma_mcu_inst.read(8'h30, rdData, rdOe);
        chk("readOe", 16'h0000, {15'h0, rdOe});
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        rdc(8'h23, 8'h00);
        chk("cellFeedback", 16'h0000, cellFeedback);
        finish_test();
    end
endmodule : tb_top
